/* File: src/adcw_regs.vh */
// register map, field positions, reset values and timing counts for the
// converter control block; definitions only
`ifndef ADCW_REGS_VH
`define ADCW_REGS_VH

// special-function register addresses
`define ADCW_ADDR_RESULT_LOW 8'hbe
`define ADCW_ADDR_RESULT_HIGH 8'hbf
`define ADCW_ADDR_CONFIG 8'hbc
`define ADCW_ADDR_GT_LOW 8'hc4
`define ADCW_ADDR_GT_HIGH 8'hc5
`define ADCW_ADDR_LT_LOW 8'hc6
`define ADCW_ADDR_LT_HIGH 8'hc7
`define ADCW_ADDR_CONTROL 8'he8

// control register fields
`define ADCW_CTL_ENABLE 7
`define ADCW_CTL_TRACK_MODE 6
`define ADCW_CTL_DONE 5
`define ADCW_CTL_BUSY 4
`define ADCW_CTL_MODE_HI 3
`define ADCW_CTL_MODE_LO 2
`define ADCW_CTL_WINDOW 1
`define ADCW_CTL_LEFT 0

// config register fields
`define ADCW_CFG_DIV_HI 7
`define ADCW_CFG_DIV_LO 5

// start-mode encodings
`define ADCW_START_SOFT 2'b00
`define ADCW_START_TIMER3 2'b01
`define ADCW_START_PIN 2'b10
`define ADCW_START_TIMER2 2'b11

// reset values
`define ADCW_RST_CONTROL 8'h00
`define ADCW_RST_CONFIG 8'h60
`define ADCW_RST_DIV 3'b011
`define ADCW_RST_RESULT 8'h00
`define ADCW_RST_GT_LOW 8'hff
`define ADCW_RST_GT_HIGH 8'hff
`define ADCW_RST_LT_LOW 8'h00
`define ADCW_RST_LT_HIGH 8'h00

// timing in converter clock periods
`define ADCW_CONV_CLOCKS 5'd16
`define ADCW_TRACK_CLOCKS 5'd3

`endif

/* File: src/adcw_control.v */
// converter control: enable, track modes, start sources, busy/done flags,
// result justification and window detector behind an 8-bit SFR port.
// assumes timer overflows are one-cycle pulses on clock; the convert-start
// pin and analog result are asynchronous to clock only where noted.
//
// How it works
// - enable bit 0 holds converter in shutdown
// - track mode 0: track except while converting
// - track mode 1: start-mode field governs tracking
// - done flag set at finish, software clears
// - done flag drives interrupt request
// - conversion lasts 16 converter clocks
// - window detector checks every result
// - window flag pollable, interrupting, software cleared
// - limit order chooses inside or outside
// - greater-than word high:low, both reset ones
// - less-than word high:low, both reset zero
// - start field picks software, timers or pin
// - busy during conversion, its fall sets done unless a disable aborted it
// - low power tracking 3 clocks or pin low
// - justify bit places result left or right
`timescale 1ns/10ps
`include "adcw_regs.vh"

module adcw_control #(
  parameter RESULT_WIDTH = 10
) (
  // system
  input wire clock,
  input wire resetn,
  // special-function register port
  input wire [7:0] sfr_addr,
  input wire sfr_write,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // start sources
  input wire timer2_overflow,
  input wire timer3_overflow,
  input wire external_convert_start,
  // analog core
  input wire [RESULT_WIDTH-1:0] sample_code,
  input wire differential,
  output wire converter_power,
  output wire track_active,
  output wire sar_tick,
  // interrupt requests (levels)
  output wire done_request,
  output wire window_request
);

  localparam ST_IDLE = 2'd0;
  localparam ST_TRACK = 2'd1;
  localparam ST_CONV = 2'd2;

  reg converter_enable;
  reg track_mode_select;
  reg conversion_done_flag;
  reg [1:0] start_mode_field;
  reg window_compare_flag;
  reg left_justify_select;
  reg [2:0] sar_clock_divider;
  reg [2:0] amplifier_gain_field;
  reg [7:0] greater_than_limit_high;
  reg [7:0] greater_than_limit_low;
  reg [7:0] less_than_limit_high;
  reg [7:0] less_than_limit_low;
  reg [7:0] result_high_byte;
  reg [7:0] result_low_byte;
  reg [1:0] state;
  reg [3:0] div_count;
  reg [4:0] tick_count;
  reg pin_meta;
  reg pin_sync;
  reg pin_last;

  wire conversion_busy = (state != ST_IDLE);
  wire ctl_write = sfr_write && (sfr_addr == `ADCW_ADDR_CONTROL);

  // converter clock period in system clocks, minus one
  reg [3:0] div_limit;
  always @* begin
    case (sar_clock_divider)
      3'd0: div_limit = 4'd0;
      3'd1: div_limit = 4'd1;
      3'd2: div_limit = 4'd3;
      3'd3: div_limit = 4'd7;
      default: div_limit = 4'd15;
    endcase
  end
  assign sar_tick = converter_enable && (div_count == div_limit);

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_count <= 4'd0;
    end else if (!converter_enable || sar_tick) begin
      div_count <= 4'd0;
    end else begin
      div_count <= div_count + 4'd1;
    end
  end

  // pin is asynchronous: two flops before any logic reads it
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      pin_meta <= external_convert_start;
      pin_sync <= pin_meta;
      pin_last <= pin_sync;
    end
  end

  // a software start may enable the converter in the same write, so it
  // decodes the written bits rather than the stored ones
  wire soft_start = ctl_write && sfr_wdata[`ADCW_CTL_ENABLE] &&
    sfr_wdata[`ADCW_CTL_BUSY] &&
    (sfr_wdata[`ADCW_CTL_MODE_HI:`ADCW_CTL_MODE_LO] == `ADCW_START_SOFT);
  reg hw_start;
  always @* begin
    case (start_mode_field)
      `ADCW_START_TIMER3: hw_start = timer3_overflow;
      `ADCW_START_PIN: hw_start = pin_sync && !pin_last;
      `ADCW_START_TIMER2: hw_start = timer2_overflow;
      default: hw_start = 1'b0;
    endcase
  end
  // any control write masks a same-cycle timer or pin start
  wire start_event = soft_start || (!ctl_write && hw_start);

  // pin mode tracks while the pin is low, so no timed track phase there
  wire timed_track = track_mode_select &&
                     (start_mode_field != `ADCW_START_PIN);

  // result formatting and window compare
  wire [15:0] right_word = {{(16-RESULT_WIDTH){differential &
                            sample_code[RESULT_WIDTH-1]}}, sample_code};
  wire [15:0] left_word = {sample_code, {(16-RESULT_WIDTH){1'b0}}};
  wire [15:0] new_word = left_justify_select ? left_word
                                             : right_word;
  wire [15:0] gt_word = {greater_than_limit_high,
                         greater_than_limit_low};
  wire [15:0] lt_word = {less_than_limit_high, less_than_limit_low};
  wire signed [16:0] r_s = {differential & new_word[15], new_word};
  wire signed [16:0] g_s = {differential & gt_word[15], gt_word};
  wire signed [16:0] l_s = {differential & lt_word[15], lt_word};
  wire above = r_s > g_s;
  wire below = r_s < l_s;
  wire in_band_mode = g_s < l_s;
  wire window_hit = in_band_mode ? (above && below)
                                 : (above || below);

  wire conv_end = (state == ST_CONV) && sar_tick &&
                  (tick_count == `ADCW_CONV_CLOCKS - 5'd1);

  // conversion sequencer
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_IDLE;
      tick_count <= 5'd0;
    end else if (!converter_enable && !soft_start) begin
      state <= ST_IDLE;
      tick_count <= 5'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          tick_count <= 5'd0;
          if (start_event) begin
            if (soft_start ? sfr_wdata[`ADCW_CTL_TRACK_MODE] : timed_track)
              state <= ST_TRACK;
            else
              state <= ST_CONV;
          end
        end
        ST_TRACK: begin
          if (sar_tick) begin
            if (tick_count == `ADCW_TRACK_CLOCKS - 5'd1) begin
              state <= ST_CONV;
              tick_count <= 5'd0;
            end else begin
              tick_count <= tick_count + 5'd1;
            end
          end
        end
        ST_CONV: begin
          if (conv_end) begin
            state <= ST_IDLE;
            tick_count <= 5'd0;
          end else if (sar_tick) begin
            tick_count <= tick_count + 5'd1;
          end
        end
        default: begin
          state <= ST_IDLE;
          tick_count <= 5'd0;
        end
      endcase
    end
  end

  // register writes; hardware set wins over a software clear
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      converter_enable <= 1'b0;
      track_mode_select <= 1'b0;
      conversion_done_flag <= 1'b0;
      start_mode_field <= 2'b00;
      window_compare_flag <= 1'b0;
      left_justify_select <= 1'b0;
      sar_clock_divider <= `ADCW_RST_DIV;
      amplifier_gain_field <= 3'b000;
      greater_than_limit_high <= `ADCW_RST_GT_HIGH;
      greater_than_limit_low <= `ADCW_RST_GT_LOW;
      less_than_limit_high <= `ADCW_RST_LT_HIGH;
      less_than_limit_low <= `ADCW_RST_LT_LOW;
      result_high_byte <= `ADCW_RST_RESULT;
      result_low_byte <= `ADCW_RST_RESULT;
    end else begin
      if (ctl_write) begin
        converter_enable <= sfr_wdata[`ADCW_CTL_ENABLE];
        track_mode_select <= sfr_wdata[`ADCW_CTL_TRACK_MODE];
        start_mode_field <= sfr_wdata[`ADCW_CTL_MODE_HI:`ADCW_CTL_MODE_LO];
        left_justify_select <= sfr_wdata[`ADCW_CTL_LEFT];
      end
      conversion_done_flag <= conv_end ||
        (ctl_write ? sfr_wdata[`ADCW_CTL_DONE]
                   : conversion_done_flag);
      window_compare_flag <= (conv_end && window_hit) ||
        (ctl_write ? sfr_wdata[`ADCW_CTL_WINDOW]
                   : window_compare_flag);
      if (sfr_write && sfr_addr == `ADCW_ADDR_CONFIG) begin
        sar_clock_divider <= sfr_wdata[`ADCW_CFG_DIV_HI:`ADCW_CFG_DIV_LO];
        amplifier_gain_field <= sfr_wdata[2:0];
      end
      if (sfr_write && sfr_addr == `ADCW_ADDR_GT_HIGH)
        greater_than_limit_high <= sfr_wdata;
      if (sfr_write && sfr_addr == `ADCW_ADDR_GT_LOW)
        greater_than_limit_low <= sfr_wdata;
      if (sfr_write && sfr_addr == `ADCW_ADDR_LT_HIGH)
        less_than_limit_high <= sfr_wdata;
      if (sfr_write && sfr_addr == `ADCW_ADDR_LT_LOW)
        less_than_limit_low <= sfr_wdata;
      // a finishing conversion overrides a same-cycle software write
      if (conv_end) begin
        result_high_byte <= new_word[15:8];
        result_low_byte <= new_word[7:0];
      end else begin
        if (sfr_write && sfr_addr == `ADCW_ADDR_RESULT_HIGH)
          result_high_byte <= sfr_wdata;
        if (sfr_write && sfr_addr == `ADCW_ADDR_RESULT_LOW)
          result_low_byte <= sfr_wdata;
      end
    end
  end

  // read data registered: valid the cycle after the address
  reg [7:0] next_rdata;
  always @* begin
    case (sfr_addr)
      `ADCW_ADDR_CONTROL:
        next_rdata = {converter_enable, track_mode_select,
                      conversion_done_flag, conversion_busy,
                      start_mode_field, window_compare_flag,
                      left_justify_select};
      `ADCW_ADDR_CONFIG:
        next_rdata = {sar_clock_divider, 2'b00, amplifier_gain_field};
      `ADCW_ADDR_RESULT_HIGH: next_rdata = result_high_byte;
      `ADCW_ADDR_RESULT_LOW: next_rdata = result_low_byte;
      `ADCW_ADDR_GT_HIGH: next_rdata = greater_than_limit_high;
      `ADCW_ADDR_GT_LOW: next_rdata = greater_than_limit_low;
      `ADCW_ADDR_LT_HIGH: next_rdata = less_than_limit_high;
      `ADCW_ADDR_LT_LOW: next_rdata = less_than_limit_low;
      default: next_rdata = 8'h00;
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= next_rdata;
  end

  assign converter_power = converter_enable;
  assign track_active = converter_enable && (state != ST_CONV) &&
    (!track_mode_select ? 1'b1 :
     (start_mode_field == `ADCW_START_PIN) ? !pin_sync :
     (state == ST_TRACK));
  assign done_request = conversion_done_flag;
  assign window_request = window_compare_flag;

endmodule

/* File: tb/adcw_control_assertions.sv */
// concurrent checks on the converter control ports, bound to the block
// assumes the divider keeps its reset setting and no config writes occur
`timescale 1ns/10ps
module adcw_control_assertions (
  input wire clock,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire sfr_write,
  input wire [7:0] sfr_wdata,
  input wire [7:0] sfr_rdata,
  input wire timer2_overflow,
  input wire timer3_overflow,
  input wire converter_power,
  input wire track_active,
  input wire sar_tick,
  input wire done_request,
  input wire window_request
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire ctl_wr = sfr_write && sfr_addr == 8'he8;
  reg [1:0] mode;
  reg tm;
  reg [4:0] ticks;
  // restart the tick count only on a start that the mode really accepts
  wire go = ctl_wr ?
    sfr_wdata[7] && sfr_wdata[4] && sfr_wdata[3:2] == 2'b00 :
    converter_power && ((timer3_overflow && mode == 2'b01) ||
    (timer2_overflow && mode == 2'b11));
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode <= 2'b00;
      tm <= 1'b0;
      ticks <= 5'd0;
    end else begin
      if (ctl_wr) begin
        mode <= sfr_wdata[3:2];
        tm <= sfr_wdata[6];
      end
      if (go) ticks <= 5'd0;
      else if (sar_tick) ticks <= ticks + 5'd1;
    end
  end
  a_enable_power: assert property (ctl_wr |=>
    converter_power == $past(sfr_wdata[7])) else $error("power bit");
  a_shutdown_quiet: assert property (!converter_power |->
    !track_active && !sar_tick) else $error("activity while off");
  a_done_sticky: assert property (done_request && !ctl_wr |=>
    done_request) else $error("done flag dropped");
  a_window_sticky: assert property (window_request && !ctl_wr |=>
    window_request) else $error("window flag dropped");
  a_poll_flags: assert property (sfr_addr == 8'he8 && !sfr_write |=>
    sfr_rdata[7] == $past(converter_power) &&
    sfr_rdata[5] == $past(done_request) &&
    sfr_rdata[1] == $past(window_request)) else $error("control readback");
  a_hold_no_track: assert property ($rose(done_request) |->
    !$past(track_active)) else $error("tracking during conversion");
  a_track_resume: assert property ($rose(done_request) && !tm |->
    track_active) else $error("tracking not resumed");
  a_conv_ticks: assert property (
    $rose(done_request) && mode != 2'b10 |->
    ticks == (tm ? 5'd19 : 5'd16)) else $error("conversion length");
  cover property ($rose(window_request));
  cover property ($rose(done_request) && tm);
  cover property ($rose(done_request) && mode == 2'b10);
endmodule
bind adcw_control adcw_control_assertions i_chk (.*);

/* File: tb/adcw_control_test.sv */
// self-checking bench for the converter control block
// assumes the divider stays at reset value; differential inputs in the second half
`timescale 1ns/10ps
module adcw_control_test;
  reg clock = 0, resetn = 0, sfr_write = 0, req = 0, lk = 0;
  reg [7:0] sfr_addr = 0, sfr_wdata = 0;
  reg timer2_overflow = 0, timer3_overflow = 0, external_convert_start = 0;
  reg [9:0] sample_code = 0, gt, lt;
  reg differential = 0, lj, tm, win;
  reg [15:0] w, gw, lw;
  reg signed [16:0] gs, ls, ws;
  reg [7:0] q[$];
  wire [7:0] sfr_rdata;
  wire converter_power, track_active, sar_tick, done_request, window_request;
  integer err_count = 0, n_compared = 0, seed = 32'hde22, i, k;
  adcw_control i_dut (.clock(clock), .resetn(resetn), .sfr_addr(sfr_addr),
    .sfr_write(sfr_write), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer2_overflow(timer2_overflow), .timer3_overflow(timer3_overflow),
    .external_convert_start(external_convert_start),
    .sample_code(sample_code), .differential(differential),
    .converter_power(converter_power), .track_active(track_active),
    .sar_tick(sar_tick), .done_request(done_request),
    .window_request(window_request));
  initial forever #10 clock = ~clock;
  task chk(input string nm, input [7:0] e, input [7:0] g);
    n_compared = n_compared + 1;
    if (g !== e) begin
      err_count = err_count + 1;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(negedge clock);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_write = 1;
    @(negedge clock);
    sfr_write = 0;
  endtask
  // read data is registered, so the monitor looks one edge after the request
  task rd(input [7:0] a, input [7:0] e);
    @(negedge clock);
    sfr_addr = a;
    req = 1;
    q.push_back(e);
    @(negedge clock);
    req = 0;
  endtask
  always @(posedge clock) lk <= req;
  always @(negedge clock) if (lk) chk("rdata", q.pop_front(), sfr_rdata);
  task wait_done;
    for (i = 0; i < 400 && done_request !== 1'b1; i = i + 1) @(negedge clock);
    if (done_request !== 1'b1) begin
      err_count = err_count + 1;
      final_report;
    end
  endtask
  task pulse(input [1:0] m);
    @(negedge clock);
    timer3_overflow = m == 2'b01;
    timer2_overflow = m == 2'b11;
    external_convert_start = m == 2'b10;
    @(negedge clock);
    timer3_overflow = 0;
    timer2_overflow = 0;
  endtask
  initial begin
    repeat (3) @(negedge clock);
    resetn = 1;
    rd(8'he8, 8'h00);
    rd(8'hbc, 8'h60);
    rd(8'hc4, 8'hff);
    rd(8'hc5, 8'hff);
    rd(8'hc6, 8'h00);
    rd(8'hc7, 8'h00);
    rd(8'hbf, 8'h00);
    rd(8'hbe, 8'h00);
    rd(8'h00, 8'h00);
    $display("test reset values done");
    for (k = 0; k < 16; k = k + 1) begin
      gt = $random(seed);
      lt = $random(seed);
      lj = $random(seed);
      tm = $random(seed);
      sample_code = $random(seed);
      // second half runs two's complement inputs
      differential = k[3];
      gw = lj ? {gt, 6'h00} : {{6{differential & gt[9]}}, gt};
      lw = lj ? {lt, 6'h00} : {{6{differential & lt[9]}}, lt};
      w = lj ? {sample_code, 6'h00} :
        {{6{differential & sample_code[9]}}, sample_code};
      gs = {differential & gw[15], gw};
      ls = {differential & lw[15], lw};
      ws = {differential & w[15], w};
      win = gs < ls ? ws > gs && ws < ls : ws > gs || ws < ls;
      wr(8'hc4, gw[7:0]);
      wr(8'hc5, gw[15:8]);
      wr(8'hc6, lw[7:0]);
      wr(8'hc7, lw[15:8]);
      wr(8'he8, {1'b1, tm, 1'b0, k[1:0] == 2'b00, k[1:0], 1'b0, lj});
      pulse(k[1:0]);
      wait_done;
      external_convert_start = 0;
      rd(8'he8, {1'b1, tm, 2'b10, k[1:0], win, lj});
      rd(8'hbf, w[15:8]);
      rd(8'hbe, w[7:0]);
      rd(8'hc5, gw[15:8]);
      rd(8'hc7, lw[15:8]);
      wr(8'he8, 8'h00);
      rd(8'he8, 8'h00);
    end
    $display("test start sources and window done");
    wr(8'he8, 8'h94);
    pulse(2'b11);
    repeat (200) @(negedge clock);
    chk("done", 8'h00, {7'h00, done_request});
    pulse(2'b01);
    wait_done;
    chk("done", 8'h01, {7'h00, done_request});
    $display("test refused starts done");
    wr(8'he8, 8'h00);
    wr(8'he8, 8'h90);
    rd(8'he8, 8'h90);
    repeat (40) @(negedge clock);
    wr(8'he8, 8'h00);
    repeat (200) @(negedge clock);
    chk("done", 8'h00, {7'h00, done_request});
    chk("power", 8'h00, {7'h00, converter_power});
    $display("test abort done");
    final_report;
  end
endmodule
